// >>> rtl/scwu_cache.sv
`timescale 1ns/1ns
`include "scwu_consts.svh"
module scwu_cache import scwu_pkg::*; #(
  parameter int SETS = 16,
  parameter logic [31:0] ID_CODE = `SCWU_ID_VALUE // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Processor port
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [`SCWU_ADDR_W-1:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic cpu_ready,
  output logic cpu_done,
  output logic [31:0] cpu_rdata,
  // Bus master side
  output logic bus_req,
  output scwu_cmd_e bus_cmd,
  output logic [`SCWU_ADDR_W-1:0] bus_addr,
  output logic [`SCWU_LINE_BITS-1:0] bus_wdata,
  output logic bus_victim,
  input wire logic bus_gnt,
  input wire logic bus_rsp_valid,
  input wire logic bus_rsp_shared,
  input wire logic [`SCWU_LINE_BITS-1:0] bus_rsp_data,
  // Snoop side
  input wire logic snp_valid,
  input wire scwu_cmd_e snp_cmd,
  input wire logic [`SCWU_ADDR_W-1:0] snp_addr,
  input wire logic [`SCWU_LINE_BITS-1:0] snp_wdata,
  output logic snp_shared,
  output logic snp_dirty,
  output logic snp_data_valid,
  output logic [`SCWU_LINE_BITS-1:0] snp_rdata,
  // Register port
  input wire logic [`SCWU_REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int IDX_BITS = $clog2(SETS);
  localparam int TAG_BITS = `SCWU_ADDR_W - `SCWU_OFS_BITS - IDX_BITS;
  localparam int LA_BITS = `SCWU_ADDR_W - `SCWU_OFS_BITS;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  function automatic logic [`SCWU_LINE_BITS-1:0] merge_word(input logic [`SCWU_LINE_BITS-1:0] line,
                                                           input logic [3:0] sel, input logic [31:0] d);
    logic [`SCWU_LINE_BITS-1:0] r;
    r = line;
    r[sel*32 +: 32] = d;
    return r;
  endfunction

  // Line store: tag, valid, shared, modified and 64 bytes of data per set
  logic [TAG_BITS-1:0] tag_mem [SETS];
  logic v_mem [SETS];
  logic s_mem [SETS];
  logic d_mem [SETS];
  logic [`SCWU_LINE_BITS-1:0] data_mem [SETS];

  scwu_state_e state_reg, state_next;
  logic rq_we_reg;
  logic [`SCWU_ADDR_W-1:0] rq_addr_reg;
  logic [31:0] rq_wdata_reg;
  logic vb_valid_reg;
  logic [LA_BITS-1:0] vb_addr_reg;
  logic [`SCWU_LINE_BITS-1:0] vb_data_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] hits_reg;
  logic keep_updates;
  assign keep_updates = ctrl_reg[`SCWU_CTRL_KEEP_BIT];

  // Processor probe
  logic [IDX_BITS-1:0] c_idx, r_idx, s_idx;
  logic [TAG_BITS-1:0] c_tag, r_tag, s_tag;
  logic [3:0] c_word, r_word;
  logic c_match, accept;
  assign c_idx = cpu_addr[`SCWU_OFS_BITS +: IDX_BITS];
  assign c_tag = cpu_addr[`SCWU_ADDR_W-1 -: TAG_BITS];
  assign c_word = cpu_addr[`SCWU_WORD_SEL_LSB +: 4];
  assign r_idx = rq_addr_reg[`SCWU_OFS_BITS +: IDX_BITS];
  assign r_tag = rq_addr_reg[`SCWU_ADDR_W-1 -: TAG_BITS];
  assign r_word = rq_addr_reg[`SCWU_WORD_SEL_LSB +: 4];
  assign c_match = v_mem[c_idx] && (tag_mem[c_idx] == c_tag);
  // Holding off while a snoop is present keeps both writers off the same set in that cycle
  assign cpu_ready = (state_reg == st_idle) && !snp_valid;
  assign accept = cpu_req && cpu_ready;

  logic rd_hit, wr_local, wr_shared, miss, miss_victim;
  assign rd_hit = accept && !cpu_we && c_match;
  assign wr_local = accept && cpu_we && c_match && !s_mem[c_idx];
  assign wr_shared = accept && cpu_we && c_match && s_mem[c_idx];
  assign miss = accept && !c_match;
  assign miss_victim = miss && v_mem[c_idx] && d_mem[c_idx];

  // Processor sequencer, next values
  logic cw_en, cw_v, cw_s, cw_d, done_next, issue, vb_load;
  logic [IDX_BITS-1:0] cw_idx;
  logic [TAG_BITS-1:0] cw_tag;
  logic [`SCWU_LINE_BITS-1:0] cw_data, bus_wdata_next, fill_line;
  logic [31:0] rdata_next;
  logic [`SCWU_ADDR_W-1:0] bus_addr_next;
  scwu_cmd_e bus_cmd_next;
  logic rsp_here;
  assign rsp_here = bus_rsp_valid && !bus_req;
  assign fill_line = rq_we_reg ? merge_word(bus_rsp_data, r_word, rq_wdata_reg) : bus_rsp_data;

  always_comb begin
    state_next = state_reg;
    cw_en = 1'b0;
    cw_idx = r_idx;
    cw_tag = tag_mem[r_idx];
    cw_v = v_mem[r_idx];
    cw_s = s_mem[r_idx];
    cw_d = d_mem[r_idx];
    cw_data = data_mem[r_idx];
    done_next = 1'b0;
    rdata_next = cpu_rdata;
    issue = 1'b0;
    bus_cmd_next = bus_cmd;
    bus_addr_next = bus_addr;
    bus_wdata_next = bus_wdata;
    vb_load = 1'b0;
    case (state_reg)
      st_idle: begin
        if (rd_hit) begin
          rdata_next = data_mem[c_idx][c_word*32 +: 32];
          done_next = 1'b1;
        end else if (wr_local) begin
          cw_en = 1'b1;
          cw_idx = c_idx;
          cw_tag = c_tag;
          cw_d = 1'b1;
          cw_v = 1'b1;
          cw_s = 1'b0;
          cw_data = merge_word(data_mem[c_idx], c_word, cpu_wdata);
          done_next = 1'b1;
        end else if (wr_shared) begin
          cw_en = 1'b1;
          cw_idx = c_idx;
          cw_tag = c_tag;
          cw_v = 1'b1;
          cw_s = 1'b1;
          cw_d = d_mem[c_idx];
          cw_data = merge_word(data_mem[c_idx], c_word, cpu_wdata);
          issue = 1'b1;
          bus_cmd_next = cmd_write;
          bus_addr_next = {cpu_addr[`SCWU_ADDR_W-1:`SCWU_OFS_BITS], {`SCWU_OFS_BITS{1'b0}}};
          bus_wdata_next = cw_data;
          state_next = st_bcast;
        end else if (miss) begin
          if (miss_victim) begin
            vb_load = 1'b1;
            cw_en = 1'b1;
            cw_idx = c_idx;
            cw_tag = tag_mem[c_idx];
            cw_v = 1'b0;
            cw_s = 1'b0;
            cw_d = 1'b0;
            cw_data = data_mem[c_idx];
          end
          issue = 1'b1;
          bus_cmd_next = cmd_read;
          bus_addr_next = {cpu_addr[`SCWU_ADDR_W-1:`SCWU_OFS_BITS], {`SCWU_OFS_BITS{1'b0}}};
          state_next = st_refill;
        end
      end
      st_refill: begin
        if (rsp_here) begin
          cw_en = 1'b1;
          cw_tag = r_tag;
          cw_v = 1'b1;
          cw_s = bus_rsp_shared;
          cw_d = rq_we_reg && !bus_rsp_shared;
          cw_data = fill_line;
          rdata_next = bus_rsp_data[r_word*32 +: 32];
          if (rq_we_reg && bus_rsp_shared) begin
            issue = 1'b1;
            bus_cmd_next = cmd_write;
            bus_wdata_next = fill_line;
            state_next = st_bcast;
          end else begin
            done_next = 1'b1;
            state_next = vb_valid_reg ? st_victim : st_idle;
          end
        end
      end
      st_bcast: begin
        if (rsp_here) begin
          cw_en = 1'b1;
          cw_s = bus_rsp_shared;
          cw_d = 1'b0;
          done_next = 1'b1;
          state_next = vb_valid_reg ? st_victim : st_idle;
        end
      end
      st_victim: begin
        if (!bus_req) begin
          issue = 1'b1;
          bus_cmd_next = cmd_write_victim;
          bus_addr_next = {vb_addr_reg, {`SCWU_OFS_BITS{1'b0}}};
          bus_wdata_next = vb_data_reg;
        end
        if (bus_req && bus_gnt) begin
          state_next = st_idle;
        end
      end
      default: state_next = st_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= st_idle;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rq_we_reg <= 1'b0;
      rq_addr_reg <= '0;
      rq_wdata_reg <= '0;
    end else if (accept) begin
      rq_we_reg <= cpu_we;
      rq_addr_reg <= cpu_addr;
      rq_wdata_reg <= cpu_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      cpu_done <= 1'b0;
      cpu_rdata <= '0;
    end else begin
      cpu_done <= done_next;
      cpu_rdata <= rdata_next;
    end
  end

  // Bus request stands until granted; victim is never requested while a refill is open
  always_ff @(posedge mclk) begin
    if (reset) begin
      bus_req <= 1'b0;
      bus_cmd <= cmd_idle;
      bus_addr <= '0;
      bus_wdata <= '0;
      bus_victim <= 1'b0;
    end else begin
      if (issue) begin
        bus_req <= 1'b1;
        bus_cmd <= bus_cmd_next;
        bus_addr <= bus_addr_next;
        bus_wdata <= bus_wdata_next;
        bus_victim <= (bus_cmd_next == cmd_write_victim);
      end else if (bus_req && bus_gnt) begin
        bus_req <= 1'b0;
        bus_victim <= 1'b0;
      end
    end
  end

  // Snoop probe
  logic s_probe, s_hit, vb_hit, s_rd, s_wr;
  logic sw_en, sw_v, sw_s, sw_d, sw_upd;
  logic rsp_sh_next, rsp_dt_next;
  assign s_idx = snp_addr[`SCWU_OFS_BITS +: IDX_BITS];
  assign s_tag = snp_addr[`SCWU_ADDR_W-1 -: TAG_BITS];
  assign s_probe = snp_valid && (snp_cmd == cmd_read || snp_cmd == cmd_write);
  assign s_rd = s_probe && (snp_cmd == cmd_read);
  assign s_wr = s_probe && (snp_cmd == cmd_write);
  assign s_hit = s_probe && v_mem[s_idx] && (tag_mem[s_idx] == s_tag);
  assign vb_hit = s_probe && vb_valid_reg && (vb_addr_reg == snp_addr[`SCWU_ADDR_W-1:`SCWU_OFS_BITS]);
  assign sw_en = s_hit;
  assign sw_v = !(s_wr && !keep_updates);
  assign sw_s = 1'b1;
  assign sw_d = s_rd && d_mem[s_idx];
  assign sw_upd = s_wr && keep_updates;
  assign rsp_sh_next = (s_rd && (s_hit || vb_hit)) || (s_wr && ((s_hit && keep_updates) || vb_hit));
  assign rsp_dt_next = s_rd && ((s_hit && d_mem[s_idx]) || vb_hit);

  always_ff @(posedge mclk) begin
    if (reset) begin
      snp_shared <= 1'b0;
      snp_dirty <= 1'b0;
      snp_data_valid <= 1'b0;
      snp_rdata <= '0;
    end else begin
      snp_shared <= rsp_sh_next;
      snp_dirty <= rsp_dt_next;
      snp_data_valid <= rsp_dt_next;
      if (rsp_dt_next) begin
        snp_rdata <= vb_hit ? vb_data_reg : data_mem[s_idx];
      end
    end
  end

  // Victim buffer; a snooped write is absorbed, but the write-back carries it only if it arrives before st_victim issues the victim request
  always_ff @(posedge mclk) begin
    if (reset) begin
      vb_valid_reg <= 1'b0;
      vb_addr_reg <= '0;
      vb_data_reg <= '0;
    end else begin
      if (vb_load) begin
        vb_valid_reg <= 1'b1;
        vb_addr_reg <= {tag_mem[c_idx], c_idx};
        vb_data_reg <= data_mem[c_idx];
      end else if (state_reg == st_victim && bus_req && bus_gnt) begin
        vb_valid_reg <= 1'b0;
      end else if (vb_hit && s_wr) begin
        vb_data_reg <= snp_wdata;
      end
    end
  end

  // Line store; processor update wins a same-set collision, which only a refill or a broadcast completion can cause
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < SETS; i++) begin
        v_mem[i] <= 1'b0;
        s_mem[i] <= 1'b0;
        d_mem[i] <= 1'b0;
      end
    end else begin
      if (sw_en && !(cw_en && cw_idx == s_idx)) begin
        v_mem[s_idx] <= sw_v;
        s_mem[s_idx] <= sw_s;
        d_mem[s_idx] <= sw_d;
        if (sw_upd) begin
          data_mem[s_idx] <= snp_wdata;
        end
      end
      if (cw_en) begin
        tag_mem[cw_idx] <= cw_tag;
        v_mem[cw_idx] <= cw_v;
        s_mem[cw_idx] <= cw_s;
        d_mem[cw_idx] <= cw_d;
        data_mem[cw_idx] <= cw_data;
      end
    end
  end

  // Registers: full 32-bit words only, reached solely through this command port
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_reg <= `SCWU_CTRL_RESET;
    end else if (reg_wr && reg_addr == `SCWU_OFF_CTRL) begin
      ctrl_reg <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      hits_reg <= '0;
    end else if (s_hit || vb_hit) begin
      hits_reg <= hits_reg + 32'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      if (reg_addr == `SCWU_OFF_CTRL) begin
        reg_rdata <= ctrl_reg;
      end else if (reg_addr == `SCWU_OFF_STATUS) begin
        reg_rdata <= {29'h0, bus_req, state_reg != st_idle, vb_valid_reg};
      end else if (reg_addr == `SCWU_OFF_HITS) begin
        reg_rdata <= hits_reg;
      end else if (reg_addr == `SCWU_OFF_ID) begin
        reg_rdata <= ID_CODE;
      end else begin
        reg_rdata <= '0;
      end
    end else begin
      reg_rdata <= '0;
    end
  end

  sequence seq_refill_issued;
    bus_req && bus_cmd == cmd_read && !bus_victim;
  endsequence
  sequence seq_victim_held;
    vb_valid_reg && !v_mem[$past(c_idx)];
  endsequence

  a_read_dirty_resp: assert property (s_rd && s_hit && d_mem[s_idx] |=> snp_shared && snp_dirty && snp_data_valid)
    else $error("modified read hit not answered shared and modified");
  a_write_keep_resp: assert property (s_wr && s_hit && keep_updates |=> snp_shared && !snp_dirty)
    else $error("kept write not answered shared clean");
  a_write_drop_inval: assert property (s_wr && s_hit && !vb_hit && !keep_updates && !cw_en
    |=> !snp_shared && !snp_dirty && !v_mem[$past(s_idx)])
    else $error("unwanted write line not invalidated silently");
  a_bcast_clean: assert property (state_reg == st_bcast && rsp_here |=> !d_mem[$past(r_idx)] && cpu_done)
    else $error("broadcast left line modified");
  a_shared_bcast: assert property (wr_shared |=> bus_req && bus_cmd == cmd_write && !bus_victim ##0 !cpu_done)
    else $error("shared write not broadcast");
  a_victim_order: assert property (miss_victim |=> seq_refill_issued ##0 seq_victim_held)
    else $error("refill not first or victim not buffered");
  a_victim_cmd: assert property (bus_req && bus_victim |-> bus_cmd == cmd_write_victim && !vb_load)
    else $error("victim indicator without victim command");
  a_ro_write: assert property (reg_wr && reg_addr != `SCWU_OFF_CTRL |=> $stable(ctrl_reg))
    else $error("read-only write changed a register");
  a_miss_quiet: assert property (snp_valid && !s_hit && !vb_hit |=> !snp_shared && !snp_dirty)
    else $error("snoop miss drew an answer");
  a_read_hit_quiet: assert property (rd_hit && !bus_req |=> cpu_done && !bus_req && state_reg == st_idle)
    else $error("read hit made bus traffic");
  a_victim_buf_serve: assert property (s_rd && vb_hit |=> snp_dirty && snp_rdata == $past(vb_data_reg))
    else $error("buffered victim not served");
endmodule // scwu_cache

// >>> rtl/scwu_consts.svh
// Functional notes
// - Snooped read hitting a modified line: answer shared and modified, supply data, line stays modified and becomes shared.
// - Snooped write on a kept line: answer shared only, absorb data, line shared clean.
// - Snooped write on an unwanted line: no answer, invalidate the line.
// - Every bus write leaves the line clean in initiator and in absorbers.
// - Processor write finding the line shared is broadcast on the bus.
// - Such broadcasts use the plain write command with victim indicator clear.
// - A valid modified line with a different tag is evicted and written back.
// - The refill read is started before the victim write-back.
// - Victim data leaves the data store and waits in a victim buffer.
// - Snooped reads and writes to a buffered victim are still served.
// - Victims go back to memory with the eviction-writeback command.
// - Register writes are always full 32 bits, no byte or half writes.
// - Writes to read-only registers are accepted but change nothing.
// - Registers are reached only through register read and write commands.
// - Tags are probed on all bus operations except eviction and register ones.
// - Blocks are 64 bytes with tag, valid, shared, modified bits.
// - Write hit needs match, valid, not shared; read hit needs match and valid.
`ifndef SCWU_CONSTS_SVH
`define SCWU_CONSTS_SVH
`define SCWU_ADDR_W 32
`define SCWU_OFS_BITS 6
`define SCWU_LINE_BITS 512
`define SCWU_WORD_SEL_LSB 2
`define SCWU_REG_AW 8
`define SCWU_OFF_CTRL 8'h00
`define SCWU_OFF_STATUS 8'h04
`define SCWU_OFF_HITS 8'h08
`define SCWU_OFF_ID 8'h0C
`define SCWU_CTRL_KEEP_BIT 0
`define SCWU_CTRL_RESET 32'h00000001
`define SCWU_ID_VALUE 32'h5C0A0001
`endif

// >>> rtl/scwu_pkg.sv
package scwu_pkg;
  typedef enum logic [2:0] {
    cmd_idle,
    cmd_read,
    cmd_write,
    cmd_write_victim,
    register_read_cmd,
    register_write_cmd
  } scwu_cmd_e;
  typedef enum logic [2:0] {
    st_idle,
    st_refill,
    st_bcast,
    st_victim
  } scwu_state_e;
endpackage

// >>> verif/scwu_bus_model.sv
`timescale 1ns/1ns
module scwu_bus_model import scwu_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Bench setup
  input wire logic [3:0] lat,
  input wire logic shared_ans,
  input wire logic [511:0] fill_line,
  // Requests from the cache
  input wire logic bus_req,
  input wire scwu_cmd_e bus_cmd,
  input wire logic [31:0] bus_addr,
  input wire logic [511:0] bus_wdata,
  input wire logic bus_victim,
  // Answers to the cache
  output logic bus_gnt,
  output logic bus_rsp_valid,
  output logic bus_rsp_shared,
  output logic [511:0] bus_rsp_data
);
  logic [4:0] wait_cnt;
  logic [4:0] rsp_cnt;
  logic rsp_due;
  scwu_cmd_e log_q[$];
  logic vic_q[$];
  logic [511:0] data_q[$];
  logic [31:0] addr_q[$];

  always @(posedge mclk) begin
    bus_gnt <= 1'h0;
    bus_rsp_valid <= 1'h0;
    // Released answer lines wander so a stale value is never taken for data
    bus_rsp_shared <= ~bus_rsp_shared;
    bus_rsp_data <= ~bus_rsp_data;
    if (reset) begin
      bus_rsp_shared <= 1'h0;
      bus_rsp_data <= '0;
      wait_cnt <= 5'h0;
      rsp_cnt <= 5'h0;
      rsp_due <= 1'h0;
    end else begin
      if (bus_req && !bus_gnt) begin
        if (wait_cnt >= {1'h0, lat}) begin
          bus_gnt <= 1'h1;
          wait_cnt <= 5'h0;
          log_q.push_back(bus_cmd);
          vic_q.push_back(bus_victim);
          data_q.push_back(bus_wdata);
          addr_q.push_back(bus_addr);
          rsp_due <= (bus_cmd != cmd_write_victim);
          rsp_cnt <= {1'h0, lat} + 5'h2;
        end else begin
          wait_cnt <= wait_cnt + 5'h1;
        end
      end
      if (rsp_due) begin
        if (rsp_cnt == 5'h0) begin
          rsp_due <= 1'h0;
          bus_rsp_valid <= 1'h1;
          bus_rsp_shared <= shared_ans;
          bus_rsp_data <= fill_line;
        end else begin
          rsp_cnt <= rsp_cnt - 5'h1;
        end
      end
    end
  end
endmodule // scwu_bus_model

// >>> verif/snoop_coherence_write_update_tb.sv
`timescale 1ns/1ns
`include "scwu_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module snoop_coherence_write_update_tb import scwu_pkg::*;;
  logic mclk, reset, cpu_req, cpu_we, cpu_ready, cpu_done;
  logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, bus_addr, snp_addr, reg_wdata, reg_rdata;
  logic bus_req, bus_victim, bus_gnt, bus_rsp_valid, bus_rsp_shared;
  logic snp_valid, snp_shared, snp_dirty, snp_data_valid, reg_wr, reg_rd, shared_ans;
  scwu_cmd_e bus_cmd, snp_cmd;
  logic [511:0] bus_wdata, bus_rsp_data, snp_wdata, snp_rdata, fill_line;
  logic [7:0] reg_addr;
  logic [3:0] lat;
  int err_count, n_tests, cyc;
  localparam logic [31:0] A_ADDR = 32'h0000_1040;
  localparam logic [31:0] B_ADDR = 32'h0000_2080;
  localparam logic [31:0] C_ADDR = 32'h0000_3080;
  localparam logic [31:0] M_ADDR = 32'h0000_5040;

  scwu_cache DUT (.mclk, .reset, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_ready, .cpu_done,
    .cpu_rdata, .bus_req, .bus_cmd, .bus_addr, .bus_wdata, .bus_victim, .bus_gnt, .bus_rsp_valid,
    .bus_rsp_shared, .bus_rsp_data, .snp_valid, .snp_cmd, .snp_addr, .snp_wdata, .snp_shared,
    .snp_dirty, .snp_data_valid, .snp_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  scwu_bus_model far_end (.mclk, .reset, .lat, .shared_ans, .fill_line, .bus_req, .bus_cmd, .bus_addr,
    .bus_wdata, .bus_victim, .bus_gnt, .bus_rsp_valid, .bus_rsp_shared, .bus_rsp_data);

  task automatic close_out();
    if (err_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    `CHK(reg_rdata, e)
  endtask

  task automatic cpu_op(input logic we, input logic [31:0] a, input logic [31:0] d);
    int i;
    far_end.log_q.delete();
    far_end.vic_q.delete();
    far_end.data_q.delete();
    far_end.addr_q.delete();
    @(posedge mclk);
    cpu_req <= 1'h1;
    cpu_we <= we;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge mclk);
    cpu_req <= 1'h0;
    #1;
    for (i = 0; i < 300 && cpu_done !== 1'h1; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask

  // Address and data swing away after each probe, as a released bus would
  task automatic snoop(input scwu_cmd_e c, input logic [31:0] a, input logic [511:0] d,
                       input logic sh, input logic dy);
    @(posedge mclk);
    snp_valid <= 1'h1;
    snp_cmd <= c;
    snp_addr <= a;
    snp_wdata <= d;
    #1;
    `CHK(cpu_ready, 1'h0)
    @(posedge mclk);
    snp_valid <= 1'h0;
    snp_addr <= ~a;
    snp_wdata <= ~d;
    #1;
    `CHK(snp_shared, sh)
    `CHK(snp_dirty, dy)
    `CHK(snp_data_valid, dy)
  endtask

  task automatic t_regs();
    reg_check(`SCWU_OFF_CTRL, `SCWU_CTRL_RESET);
    reg_check(`SCWU_OFF_ID, `SCWU_ID_VALUE);
    reg_write(`SCWU_OFF_ID, 32'hFFFF_FFFF);
    reg_check(`SCWU_OFF_ID, `SCWU_ID_VALUE);
    reg_write(`SCWU_OFF_HITS, 32'h0000_00FF);
    reg_check(`SCWU_OFF_HITS, 32'h0);
    reg_check(8'h10, 32'h0);
    reg_write(`SCWU_OFF_CTRL, 32'h0);
    reg_check(`SCWU_OFF_CTRL, 32'h0);
    reg_write(`SCWU_OFF_CTRL, 32'h1);
    reg_check(`SCWU_OFF_CTRL, 32'h1);
  endtask

  task automatic t_shared_write();
    scwu_cmd_e ign[3] = '{cmd_write_victim, register_read_cmd, register_write_cmd};
    lat = 4'h2;
    shared_ans = 1'h1;
    cpu_op(1'h1, A_ADDR, 32'hCAFE_0001);
    `CHK(far_end.log_q.size(), 2)
    `CHK(far_end.log_q[0], cmd_read)
    `CHK(far_end.log_q[1], cmd_write)
    `CHK(far_end.vic_q[1], 1'h0)
    `CHK(far_end.data_q[1][31:0], 32'hCAFE_0001)
    `CHK(far_end.addr_q[0], A_ADDR)
    `CHK(far_end.addr_q[1], A_ADDR)
    cpu_op(1'h0, A_ADDR, 32'h0);
    `CHK(cpu_rdata, 32'hCAFE_0001)
    `CHK(far_end.log_q.size(), 0)
    cpu_op(1'h1, A_ADDR + 32'h4, 32'hCAFE_0003);
    `CHK(far_end.log_q.size(), 1)
    `CHK(far_end.log_q[0], cmd_write)
    `CHK(far_end.vic_q[0], 1'h0)
    `CHK(far_end.addr_q[0], A_ADDR)
    `CHK(far_end.data_q[0][63:0], {32'hCAFE_0003, 32'hCAFE_0001})
    snoop(cmd_read, A_ADDR, '0, 1'h1, 1'h0);
    snoop(cmd_read, M_ADDR, '0, 1'h0, 1'h0);
    foreach (ign[k]) snoop(ign[k], A_ADDR, '0, 1'h0, 1'h0);
  endtask

  task automatic t_snoop_write();
    snoop(cmd_write, A_ADDR, {16{32'hA5A5_0001}}, 1'h1, 1'h0);
    cpu_op(1'h0, A_ADDR, 32'h0);
    `CHK(cpu_rdata, 32'hA5A5_0001)
    `CHK(far_end.log_q.size(), 0)
    reg_write(`SCWU_OFF_CTRL, 32'h0);
    snoop(cmd_write, A_ADDR, {16{32'h0BAD_0BAD}}, 1'h0, 1'h0);
    cpu_op(1'h0, A_ADDR, 32'h0);
    `CHK(far_end.log_q[0], cmd_read)
    `CHK(cpu_rdata, 32'h1234_5678)
    reg_write(`SCWU_OFF_CTRL, 32'h1);
  endtask

  task automatic t_dirty_snoop();
    logic [511:0] seen;
    shared_ans = 1'h0;
    cpu_op(1'h1, B_ADDR, 32'hBEEF_0002);
    `CHK(far_end.log_q.size(), 1)
    cpu_op(1'h1, B_ADDR + 32'h4, 32'hBEEF_0003);
    `CHK(far_end.log_q.size(), 0)
    snoop(cmd_read, B_ADDR, '0, 1'h1, 1'h1);
    `CHK(snp_rdata[63:0], {32'hBEEF_0003, 32'hBEEF_0002})
    // Memory stays off the bus while the modified answer is up, so only our line is seen
    seen = snp_dirty ? snp_rdata : fill_line;
    `CHK(seen[31:0], 32'hBEEF_0002)
    snoop(cmd_read, B_ADDR, '0, 1'h1, 1'h1);
  endtask

  // Long grant latency keeps the victim parked while it is probed
  task automatic t_victim();
    int i;
    lat = 4'h8;
    cpu_op(1'h0, C_ADDR, 32'h0);
    `CHK(cpu_rdata, 32'h1234_5678)
    snoop(cmd_read, B_ADDR, '0, 1'h1, 1'h1);
    `CHK(snp_rdata[31:0], 32'hBEEF_0002)
    reg_check(`SCWU_OFF_STATUS, 32'h7);
    for (i = 0; i < 60 && far_end.log_q.size() < 2; i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
    `CHK(far_end.log_q.size(), 2)
    `CHK(far_end.log_q[0], cmd_read)
    `CHK(far_end.log_q[1], cmd_write_victim)
    `CHK(far_end.vic_q[1], 1'h1)
    `CHK(far_end.data_q[1][63:0], {32'hBEEF_0003, 32'hBEEF_0002})
    `CHK(far_end.addr_q[0], C_ADDR)
    `CHK(far_end.addr_q[1], B_ADDR)
    snoop(cmd_read, B_ADDR, '0, 1'h0, 1'h0);
    reg_check(`SCWU_OFF_STATUS, 32'h0);
    reg_check(`SCWU_OFF_HITS, 32'h6);
  endtask

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    reset = 1'h1;
    {cpu_req, cpu_we, snp_valid, reg_wr, reg_rd} = 5'h0;
    {cpu_addr, cpu_wdata, snp_addr, reg_wdata} = '0;
    reg_addr = 8'h0;
    snp_cmd = cmd_idle;
    snp_wdata = '0;
    lat = 4'h2;
    shared_ans = 1'h1;
    fill_line = {16{32'h1234_5678}};
    repeat (6) @(posedge mclk);
    reset <= 1'h0;
    t_regs();
    t_shared_write();
    t_snoop_write();
    t_dirty_snoop();
    t_victim();
    repeat (4) @(posedge mclk);
    close_out();
  end
endmodule // snoop_coherence_write_update_tb
